// *** pmf_port.sv ***
// Program-memory flash port: three-select asynchronous 16-bit bus master.
// Assumes same-clock core requests; data pins come from outside the clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

// What this block does
// (R1) Three separate active-low select outputs reach the program-memory bus.
// (R2) Select zero is the boot flash, and each region is 16 bits wide and up to 256Mb.
// (R3) Selects one and two are optional extra flash or peripheral regions.
// (R4) A spare output carries the top address bit to reach the full region size.
// (R5) The boot part on select zero is a standard parallel NOR flash, one or more banks.
// (R6) Each wait count is programmable up to 31 steps.
// (R7) A wait step is 6ns and the read count covers the slowest access path.
// (R8) A read drives select and output enable low and samples only after the read wait.
// (R9) Select and address stand for the setup count before the write strobe falls.
// (R10) The write strobe stays low for the pulse count.
// (R11) Select stays active for the hold count after the write strobe rises.
// (R12) Write data stands before the write strobe rises and through the hold.
// (R13) No wait count is ever zero.
// (R14) The four wait counts are kept per select in writable configuration.
module pmf_port (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       cfg_wr_en,
    input  wire logic [1:0]                 cfg_wr_sel,
    input  wire pmf_pkg::pmf_wait_t         cfg_wr_data,
    output logic                            cfg_reject,
    input  wire logic                       req_valid,
    input  wire pmf_pkg::pmf_req_t          req,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic                            rsp_err,
    output logic [`PMF_DATA_W-1:0]          rsp_rdata,
    output logic                            boot_flash_select_n,
    output logic                            aux_select_one_n,
    output logic                            aux_select_two_n,
    output logic                            read_strobe_n,
    output logic                            write_strobe_n,
    output logic [`PMF_PIN_ADDR_W-1:0]      mem_addr,
    output logic                            mem_addr_spare,
    input  wire logic [`PMF_DATA_W-1:0]     mem_data_in,
    output logic [`PMF_DATA_W-1:0]          mem_data_out,
    output logic                            mem_data_oe_n
);

    localparam pmf_pkg::pmf_state_t STATE_RST = '{
        phase: pmf_pkg::PH_IDLE, sel_n: `PMF_SEL_NONE, rd_n: 1'b1,
        wr_n: 1'b1, data_oe_n: 1'b1, ready: 1'b1, default: '0};

    pmf_pkg::pmf_state_t st_q;
    pmf_pkg::pmf_state_t st_d;
    pmf_pkg::pmf_wait_t  wait_cfg;
    logic                accept;

    // Wait steps to core cycles, rounded up so every least time holds
    // 31 steps is 186 ns, four cycles, so the 4-bit count never wraps
    function automatic logic [`PMF_CNT_W-1:0] steps_to_cycles(
        input logic [`PMF_WAIT_W-1:0] steps);  // (R6)
        int t;
        t = (int'(steps) * `PMF_WAIT_STEP_PS + `PMF_CLK_PERIOD_PS - 1)
            / `PMF_CLK_PERIOD_PS;  // (R7)
        if (t < 1) begin
            t = 1;  // (R13)
        end
        return t[`PMF_CNT_W-1:0];
    endfunction

    // One-hot active-low select for the latched region
    function automatic logic [`PMF_NUM_SEL-1:0] select_lines(input logic [1:0] sel);
        logic [`PMF_NUM_SEL-1:0] s;
        s = `PMF_SEL_NONE;
        s[sel] = 1'b0;
        return s;
    endfunction

    // A request is taken only while the sequencer is idle
    assign accept = req_valid && st_q.ready;

    // Per-select timing, loaded on acceptance and frozen for the transfer
    pmf_cfg_bank u_bank (
        .clk       (clk),
        .reset     (reset),
        .wr_en     (cfg_wr_en),
        .wr_sel    (cfg_wr_sel),
        .wr_data   (cfg_wr_data),
        .rd_en     (accept),
        .rd_sel    (req.sel),
        .rd_data   (wait_cfg),
        .wr_reject (cfg_reject)
    );

    // Sequencer; pin values are computed here so every pin is a flop
    always_comb begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        st_d.rsp_err = 1'b0;
        // Two-stage synchroniser, first stage read by nothing else
        st_d.din_meta = mem_data_in;
        st_d.din_sync = st_q.din_meta;
        unique case (st_q.phase)
            // Idle: take a request, answer a fourth region at once
            pmf_pkg::PH_IDLE: begin
                if (accept) begin
                    st_d.write = req.write;
                    st_d.sel = req.sel;
                    st_d.wdata = req.wdata;
                    st_d.addr = req.addr[`PMF_PIN_ADDR_W-1:0];
                    st_d.addr_hi = req.addr[`PMF_ADDR_W-1];  // (R4)
                    if (req.sel > `PMF_SEL_AUX_TWO) begin
                        st_d.rsp_valid = 1'b1;  // No fourth region: refused
                        st_d.rsp_err = 1'b1;
                    end else begin
                        st_d.ready = 1'b0;
                        st_d.phase = pmf_pkg::PH_FETCH;
                    end
                end
            end
            // Drive the select; the direction picks the first timed phase
            pmf_pkg::PH_FETCH: begin
                st_d.sel_n = select_lines(st_q.sel);  // (R1)
                if (st_q.write) begin
                    st_d.data_oe_n = 1'b0;  // (R12)
                    st_d.count = steps_to_cycles(wait_cfg.wr_setup) - 4'h1;  // (R9)
                    st_d.phase = pmf_pkg::PH_WR_SETUP;
                end else begin
                    st_d.rd_n = 1'b0;  // (R8)
                    // Extra cycles cover the synchroniser latency
                    st_d.count = steps_to_cycles(wait_cfg.rd)
                               + 4'(`PMF_SYNC_STAGES) - 4'h1;  // (R7)
                    st_d.phase = pmf_pkg::PH_RD_WAIT;
                end
            end
            // Read: sample once the wait and the synchroniser are spent
            pmf_pkg::PH_RD_WAIT: begin
                if (st_q.count == '0) begin
                    st_d.rdata = st_q.din_sync;  // (R8)
                    st_d.sel_n = `PMF_SEL_NONE;
                    st_d.rd_n = 1'b1;
                    st_d.rsp_valid = 1'b1;
                    st_d.ready = 1'b1;
                    st_d.phase = pmf_pkg::PH_IDLE;
                end else begin
                    st_d.count = st_q.count - 4'h1;
                end
            end
            // Setup: select and address stand before the strobe falls
            pmf_pkg::PH_WR_SETUP: begin
                if (st_q.count == '0) begin
                    st_d.wr_n = 1'b0;  // (R9)
                    st_d.count = steps_to_cycles(wait_cfg.wr_pulse) - 4'h1;  // (R10)
                    st_d.phase = pmf_pkg::PH_WR_PULSE;
                end else begin
                    st_d.count = st_q.count - 4'h1;
                end
            end
            // Pulse: strobe low for the programmed count
            pmf_pkg::PH_WR_PULSE: begin
                if (st_q.count == '0) begin
                    st_d.wr_n = 1'b1;  // (R10)
                    st_d.count = steps_to_cycles(wait_cfg.wr_hold) - 4'h1;  // (R11)
                    st_d.phase = pmf_pkg::PH_WR_HOLD;
                end else begin
                    st_d.count = st_q.count - 4'h1;
                end
            end
            // Hold: select and data stay after the strobe rises
            pmf_pkg::PH_WR_HOLD: begin
                if (st_q.count == '0) begin
                    st_d.sel_n = `PMF_SEL_NONE;  // (R11)
                    st_d.data_oe_n = 1'b1;  // (R12)
                    st_d.rsp_valid = 1'b1;
                    st_d.ready = 1'b1;
                    st_d.phase = pmf_pkg::PH_IDLE;
                end else begin
                    st_d.count = st_q.count - 4'h1;
                end
            end
            default: begin
                st_d = STATE_RST;  // Three-bit phase has unused codes
            end
        endcase
    end

    // State register; reset releases every pin at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Answers straight from the state register
    assign req_ready           = st_q.ready;
    assign rsp_valid           = st_q.rsp_valid;
    assign rsp_err             = st_q.rsp_err;
    assign rsp_rdata           = st_q.rdata;

    // Selects: at most one low, released between transfers
    assign boot_flash_select_n = st_q.sel_n[0];  // (R2)
    assign aux_select_one_n    = st_q.sel_n[1];  // (R3)
    assign aux_select_two_n    = st_q.sel_n[2];  // (R3)

    // Strobes idle high, so reset never looks like an access
    assign read_strobe_n       = st_q.rd_n;
    assign write_strobe_n      = st_q.wr_n;

    // Address and write data hold after a transfer ends
    assign mem_addr            = st_q.addr;
    assign mem_addr_spare      = st_q.addr_hi;  // (R4)
    assign mem_data_out        = st_q.wdata;
    assign mem_data_oe_n       = st_q.data_oe_n;

endmodule

`default_nettype wire

// *** pmf_cfg.svh ***
// Constants of the program-memory flash port: timing, widths, resets.
// Assumes inclusion by bare name from the package and design modules.
`ifndef PMF_CFG_SVH
`define PMF_CFG_SVH

// Core clock period and wait-state step, in picoseconds
`define PMF_CLK_PERIOD_PS   50000
`define PMF_WAIT_STEP_PS    6000

// Data bus, word address and wait-count widths
`define PMF_DATA_W          16
`define PMF_ADDR_W          24
`define PMF_PIN_ADDR_W      23
`define PMF_WAIT_W          5
`define PMF_CNT_W           4

// Chip-select numbering and count
`define PMF_NUM_SEL         3
`define PMF_SEL_BOOT        2'h0
`define PMF_SEL_AUX_ONE     2'h1
`define PMF_SEL_AUX_TWO     2'h2
`define PMF_SEL_NONE        3'h7

// Synchroniser depth on the read data pins
`define PMF_SYNC_STAGES     2

// Reset wait counts: slowest setting, safe for any attached part
`define PMF_RST_WAIT        5'h1F

`endif

// *** pmf_pkg.sv ***
// Types shared by the program-memory flash port and its config bank.
// Assumes pmf_cfg.svh is on the include path.
`include "pmf_cfg.svh"

package pmf_pkg;

    // Wait counts of one chip-select region, in 6 ns steps
    typedef struct packed {
        logic [`PMF_WAIT_W-1:0] rd;
        logic [`PMF_WAIT_W-1:0] wr_setup;
        logic [`PMF_WAIT_W-1:0] wr_pulse;
        logic [`PMF_WAIT_W-1:0] wr_hold;
    } pmf_wait_t;

    // One access request from the core side
    typedef struct packed {
        logic                   write;
        logic [1:0]             sel;
        logic [`PMF_ADDR_W-1:0] addr;
        logic [`PMF_DATA_W-1:0] wdata;
    } pmf_req_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_FETCH,
        PH_RD_WAIT,
        PH_WR_SETUP,
        PH_WR_PULSE,
        PH_WR_HOLD
    } pmf_phase_t;

    // Whole state of the port sequencer
    typedef struct packed {
        pmf_phase_t                 phase;
        logic [`PMF_CNT_W-1:0]      count;
        logic                       write;
        logic [`PMF_PIN_ADDR_W-1:0] addr;
        logic                       addr_hi;
        logic [`PMF_DATA_W-1:0]     wdata;
        logic [`PMF_DATA_W-1:0]     rdata;
        logic [1:0]                 sel;
        logic [`PMF_NUM_SEL-1:0]    sel_n;
        logic                       rd_n;
        logic                       wr_n;
        logic                       data_oe_n;
        logic                       ready;
        logic                       rsp_valid;
        logic                       rsp_err;
        logic [`PMF_DATA_W-1:0]     din_meta;
        logic [`PMF_DATA_W-1:0]     din_sync;
    } pmf_state_t;

    // Whole state of the config bank
    typedef struct packed {
        pmf_wait_t [`PMF_NUM_SEL-1:0] slot;
        pmf_wait_t                    rd_data;
        logic                         reject;
    } pmf_bank_t;

endpackage

// *** pmf_cfg_bank.sv ***
// Per-chip-select wait-count storage with registered read port.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

module pmf_cfg_bank (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               wr_en,
    input  wire logic [1:0]         wr_sel,
    input  wire pmf_pkg::pmf_wait_t wr_data,
    input  wire logic               rd_en,
    input  wire logic [1:0]         rd_sel,
    output pmf_pkg::pmf_wait_t      rd_data,
    output logic                    wr_reject
);

    localparam pmf_pkg::pmf_wait_t WAIT_RST = '{
        rd: `PMF_RST_WAIT, wr_setup: `PMF_RST_WAIT,
        wr_pulse: `PMF_RST_WAIT, wr_hold: `PMF_RST_WAIT};

    localparam pmf_pkg::pmf_bank_t BANK_RST = '{
        slot: {`PMF_NUM_SEL{WAIT_RST}}, rd_data: WAIT_RST, reject: 1'b0};

    pmf_pkg::pmf_bank_t bank_q;
    pmf_pkg::pmf_bank_t bank_d;
    logic               zero_field;

    // A zero count is never stored; bad selects are refused too
    always_comb begin
        bank_d = bank_q;
        zero_field = (wr_data.rd == '0) || (wr_data.wr_setup == '0)
                  || (wr_data.wr_pulse == '0) || (wr_data.wr_hold == '0);  // (R13)
        bank_d.reject = 1'b0;
        if (wr_en) begin
            if (zero_field || (wr_sel > `PMF_SEL_AUX_TWO)) begin
                bank_d.reject = 1'b1;  // (R13)
            end else begin
                bank_d.slot[wr_sel] = wr_data;  // (R14)
            end
        end
        // Read held between loads, so a transfer sees fixed timing
        if (rd_en && (rd_sel <= `PMF_SEL_AUX_TWO)) begin
            bank_d.rd_data = bank_q.slot[rd_sel];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bank_q <= BANK_RST;
        end else begin
            bank_q <= bank_d;
        end
    end

    assign rd_data   = bank_q.rd_data;
    assign wr_reject = bank_q.reject;

endmodule

`default_nettype wire

// *** pmf_port_properties.sv ***
// Pin timing checks of the program-memory flash port.
// Assumes it is bound to pmf_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

module pmf_port_checker (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               cfg_wr_en,
    input wire logic [1:0]         cfg_wr_sel,
    input wire pmf_pkg::pmf_wait_t cfg_wr_data,
    input wire logic               cfg_reject,
    input wire logic               req_valid,
    input wire pmf_pkg::pmf_req_t  req,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    input wire logic               rsp_err,
    input wire logic               boot_flash_select_n,
    input wire logic               aux_select_one_n,
    input wire logic               aux_select_two_n,
    input wire logic               read_strobe_n,
    input wire logic               write_strobe_n,
    input wire logic [22:0]        mem_addr,
    input wire logic               mem_addr_spare,
    input wire logic [15:0]        mem_data_out,
    input wire logic               mem_data_oe_n
);
    logic [2:0] sels;
    logic       take;
    logic       bad;
    // Select vector, accepted request, refused config write
    assign sels = {aux_select_two_n, aux_select_one_n, boot_flash_select_n};
    assign take = req_valid && req_ready;
    assign bad = cfg_wr_sel == 2'h3 || cfg_wr_data.rd == 5'h00 || cfg_wr_data.wr_setup == 5'h00
        || cfg_wr_data.wr_pulse == 5'h00 || cfg_wr_data.wr_hold == 5'h00;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Strobe phases; 4 cycles is the longest count
    sequence s_rd_low;
        (!read_strobe_n)[*3];
    endsequence
    sequence s_wr_pulse;
        !write_strobe_n ##[1:4] write_strobe_n;
    endsequence

    property p_one_sel;
        $onehot0(~sels);
    endproperty
    property p_sel_map;
        take && req.sel != 2'h3 |-> ##2 sels == ~(3'h1 << $past(req.sel, 2));
    endproperty
    property p_addr;
        take && req.sel != 2'h3 |=> {mem_addr_spare, mem_addr} == $past(req.addr);
    endproperty
    property p_rd_len;
        $fell(read_strobe_n) |-> s_rd_low ##[1:4] read_strobe_n;
    endproperty
    property p_rd_end;
        $rose(read_strobe_n) |-> rsp_valid && !rsp_err;
    endproperty
    property p_wr_setup;
        $fell(write_strobe_n) |-> $past(sels) != 3'h7 && $stable(mem_addr);
    endproperty
    property p_wr_pulse;
        $fell(write_strobe_n) |-> s_wr_pulse;
    endproperty
    property p_wr_hold;
        $rose(write_strobe_n) |-> sels != 3'h7 && !mem_data_oe_n && $stable(mem_data_out);
    endproperty
    property p_cfg;
        cfg_wr_en |=> cfg_reject == $past(bad);
    endproperty
    property p_err;
        take && req.sel == 2'h3 |=> rsp_valid && rsp_err && sels == 3'h7;
    endproperty

    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    a_sel_map: assert property (p_sel_map) else $error("wrong select");
    a_addr: assert property (p_addr) else $error("address pins wrong");
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");
    a_rd_end: assert property (p_rd_end) else $error("read end no response");
    a_wr_setup: assert property (p_wr_setup) else $error("write setup");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length");
    a_wr_hold: assert property (p_wr_hold) else $error("write hold");
    a_cfg: assert property (p_cfg) else $error("config refusal");
    a_err: assert property (p_err) else $error("missing select refusal");
endmodule

bind pmf_port pmf_port_checker i_chk (.clk, .reset, .cfg_wr_en, .cfg_wr_sel, .cfg_wr_data,
    .cfg_reject, .req_valid, .req, .req_ready, .rsp_valid, .rsp_err, .boot_flash_select_n,
    .aux_select_one_n, .aux_select_two_n, .read_strobe_n, .write_strobe_n, .mem_addr,
    .mem_addr_spare, .mem_data_out, .mem_data_oe_n);
`default_nettype wire

// *** pmf_flash_model.sv ***
// Behavioural NOR flash on the program-memory bus, three regions.
// Assumes the port's select, strobe and address pins; bus toggles otherwise.
`timescale 1ns/1ps
`default_nettype none

module pmf_flash_model (
    input  wire logic        clk,
    input  wire logic        boot_flash_select_n,
    input  wire logic        aux_select_one_n,
    input  wire logic        aux_select_two_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [22:0] mem_addr,
    input  wire logic        mem_addr_spare,
    input  wire logic [15:0] mem_data_out,
    output logic      [15:0] mem_data_in
);
    logic [15:0] mem [logic [25:0]];
    logic [25:0] key;
    logic        on;
    logic [15:0] bus_q = 16'h5A5A;
    // Region index and word address form the array key
    assign on = !(boot_flash_select_n && aux_select_one_n && aux_select_two_n);
    assign key = {(!boot_flash_select_n ? 2'h0 : (!aux_select_one_n ? 2'h1 : 2'h2)),
                  mem_addr_spare, mem_addr};
    // Word stored at the strobe's rising edge
    always @(posedge write_strobe_n) begin
        if (on)
            mem[key] = mem_data_out;
    end
    // Released bus toggles every cycle so a stale word never matches
    always @(negedge clk) begin
        if (on && !read_strobe_n && mem.exists(key))
            bus_q <= mem[key];
        else
            bus_q <= ~bus_q;
    end
    assign mem_data_in = bus_q;
endmodule
`default_nettype wire

// *** test_program_memory_flash_port.sv ***
// Self-checking bench of the flash port with a NOR flash model.
// Assumes pmf_port, pmf_flash_model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

module test_program_memory_flash_port;
    logic clk, reset, cfg_wr_en, cfg_reject, req_valid, req_ready, rsp_valid, rsp_err;
    logic boot_flash_select_n, aux_select_one_n, aux_select_two_n;
    logic read_strobe_n, write_strobe_n, mem_addr_spare, mem_data_oe_n;
    logic [1:0]         cfg_wr_sel;
    logic [22:0]        mem_addr;
    logic [15:0]        rsp_rdata, mem_data_in, mem_data_out;
    pmf_pkg::pmf_wait_t cfg_wr_data, w;
    pmf_pkg::pmf_req_t  req;
    int                 n_errors, total_checks, seed;

    pmf_port i_dut (.clk, .reset, .cfg_wr_en, .cfg_wr_sel, .cfg_wr_data, .cfg_reject,
        .req_valid, .req, .req_ready, .rsp_valid, .rsp_err, .rsp_rdata, .boot_flash_select_n,
        .aux_select_one_n, .aux_select_two_n, .read_strobe_n, .write_strobe_n, .mem_addr,
        .mem_addr_spare, .mem_data_in, .mem_data_out, .mem_data_oe_n);
    pmf_flash_model i_mem (.clk, .boot_flash_select_n, .aux_select_one_n, .aux_select_two_n,
        .read_strobe_n, .write_strobe_n, .mem_addr, .mem_addr_spare, .mem_data_out,
        .mem_data_in);

    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cycles per wait count, rounded up to whole clocks
    function automatic int cyc(input logic [4:0] n);
        return (int'(n) * 6 + 49) / 50;
    endfunction

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        total_checks++;
        if (got != exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One config write; refusal shows the cycle after
    task automatic cfg(input logic [1:0] s, input pmf_pkg::pmf_wait_t v, input logic bad);
        cfg_wr_en = 1'b1;
        cfg_wr_sel = s;
        cfg_wr_data = v;
        @(negedge clk);
        cfg_wr_en = 1'b0;
        chk_val(16'(cfg_reject), 16'(bad), "config refusal");
        @(negedge clk);
    endtask

    // One transfer: latency to response and strobe-low cycles are measured
    task automatic xfer(input logic wr, input logic [1:0] s, input logic [23:0] a,
                        input logic [15:0] d, input int lat, input int lo);
        int k;
        int n;
        req_valid = 1'b1;
        req = '{wr, s, a, d};
        @(negedge clk);
        req_valid = 1'b0;
        k = 1;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            n += int'(!(wr ? write_strobe_n : read_strobe_n));
            @(negedge clk);
            k++;
            if (k > 40) begin
                n_errors++;
                $display("[FAIL] %0t no response", $time);
                final_report();
            end
        end
        chk_cnt(k, lat, "latency");
        chk_cnt(n, lo, "strobe low cycles");
        chk_val(16'(rsp_err), 16'(s == 2'h3), "error flag");
        if (!wr && s != 2'h3)
            chk_val(rsp_rdata, d, "read data");
    endtask

    // Write a random word then read it back on the same region
    task automatic pair(input logic [1:0] s, input pmf_pkg::pmf_wait_t v);
        logic [23:0] a;
        logic [15:0] d;
        int          lw;
        a = 24'($urandom);
        d = 16'($urandom);
        lw = 2 + cyc(v.wr_setup) + cyc(v.wr_pulse) + cyc(v.wr_hold);
        xfer(1'b1, s, a, d, lw, cyc(v.wr_pulse));
        xfer(1'b0, s, a, d, 4 + cyc(v.rd), cyc(v.rd) + 2);
    endtask

    // Main sequence, inputs changed at the falling edge
    initial begin
        reset = 1'b1;
        cfg_wr_en = 1'b0;
        cfg_wr_sel = 2'h0;
        cfg_wr_data = '0;
        req_valid = 1'b0;
        req = '0;
        n_errors = 0;
        total_checks = 0;
        seed = $urandom(32'h748F3878);
        repeat (4) @(negedge clk);
        reset = 1'b0;
        chk_val(16'({boot_flash_select_n, aux_select_one_n, aux_select_two_n, read_strobe_n,
            write_strobe_n, mem_data_oe_n, req_ready}), 16'h007F, "idle pins");
        w = '{5'h1F, 5'h1F, 5'h1F, 5'h1F};
        pair(2'h0, w);
        $display("test reset counts done");
        cfg(2'h1, '{5'h1F, 5'h00, 5'h01, 5'h01}, 1'b1);
        cfg(2'h3, '{5'h01, 5'h01, 5'h01, 5'h01}, 1'b1);
        pair(2'h1, w);
        xfer(1'b0, 2'h3, 24'h000000, 16'h0000, 1, 0);
        $display("test refusals done");
        for (int i = 0; i < 16; i++) begin
            case (i)
                0: w = '{5'h01, 5'h01, 5'h01, 5'h01};
                1: w = '{5'h08, 5'h09, 5'h10, 5'h11};
                2: w = '{5'h19, 5'h1A, 5'h1F, 5'h01};
                default: w = '{5'($urandom_range(31, 1)), 5'($urandom_range(31, 1)),
                               5'($urandom_range(31, 1)), 5'($urandom_range(31, 1))};
            endcase
            cfg(i < 3 ? 2'(i) : 2'($urandom_range(2, 0)), w, 1'b0);
            pair(cfg_wr_sel, w);
        end
        $display("test wait counts done");
        final_report();
    end
endmodule
`default_nettype wire
